// >>> rtl/rxd_pkg.sv
// Constants and types for the receive DMA channel state block.
// Assumes a 32-bit APB register port and byte-wide endpoint receive data.
package rxd_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_SKIP    = 8'h00;
  localparam logic [7:0] ADDR_HEAD    = 8'h04;
  localparam logic [7:0] ADDR_START   = 8'h08;
  localparam logic [7:0] ADDR_ACTIVE  = 8'h0C;
  localparam logic [7:0] ADDR_BUFADDR = 8'h10;
  localparam logic [7:0] ADDR_LENGTH  = 8'h14;
  localparam logic [7:0] ADDR_COUNT   = 8'h18;
  localparam logic [7:0] ADDR_COMP    = 8'h1C;

  // Field positions and widths
  localparam int          PTR_LSB     = 2;
  localparam int          INPKT_BIT   = 0;
  localparam int          MODE_BIT    = 0;
  localparam int          SKIP_W      = 8;
  localparam int          HALF_LSB    = 16;

  // Reset values
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [29:0] RST_PTR     = 30'h0000_0000;
  localparam logic [15:0] RST_HALF    = 16'h0000;
  localparam logic [7:0]  RST_SKIP    = 8'h00;

  // Length write-back into the start descriptor, and the byte store lane
  localparam logic [31:0] DESC_LEN_OFS = 32'h0000_0008;
  localparam logic [3:0]  BE_LOW_HALF  = 4'h3;
  localparam logic [3:0]  BE_BYTE0     = 4'h1;

  // Channel sequencing states
  typedef enum logic [1:0] {RXD_IDLE, RXD_BYTE, RXD_LEN} rxd_state_type;

endpackage

// >>> rtl/rxd_pair_buffer.sv
// Two-entry valid/ready buffer for received bytes.
// Assumes one clock; both sides follow the valid/ready handshake.
`timescale 1ns/1ps
module rxd_pair_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  // Handshake flags and pointer updates
  always_comb
  begin
    in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    out_valid = (cnt_reg != '0);
    out_data  = mem_reg[rd_reg];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_next   = wr_reg;
    rd_next   = rd_reg;
    if (push)
      wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
    if (pop)
      rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage and pointers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      if (push)
        mem_reg[wr_reg] <= in_data;
    end
  end

endmodule

// >>> rtl/rxd_channel.sv
// Receive DMA channel state: APB state words, byte stores, length write-back.
// Assumes an APB master, a memory write port with valid/ready and an endpoint
// byte stream with an end-of-packet marker on the last byte.
//
// Summary of operation
// - Head word bits 31..2 hold the receive queue head pointer, bits 1..0 read zero.
// - Start word bits 31..2 capture the first descriptor of the packet in progress.
// - Start word bit 0 reads 1 while a packet is in progress, else 0.
// - Active word bits 31..2 hold the descriptor of the buffer being filled.
// - Buffer address word holds the full byte address of the next stored byte.
// - Length bits 31..16 count packet bytes, written to start descriptor byte offset 8 at end.
// - Length bits 15..0 count free bytes left in the active buffer.
// - A programmed 8-bit skip count offsets the first buffer of each packet.
// - A compare-mode write matching the completion pointer drops the queue interrupt, unless a packet closes in the same cycle.
`timescale 1ns/1ps
module rxd_channel (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Endpoint receive bytes
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  // Memory write port
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  output logic      [3:0]  mem_be,
  // Receive queue interrupt level
  output logic             rx_queue_irq
);

  rxd_pkg::rxd_state_type state_reg, state_next;
  logic [7:0]  skip_reg, skip_next;
  logic [29:0] head_reg, head_next;
  logic [29:0] first_reg, first_next;
  logic        inpkt_reg, inpkt_next;
  logic [29:0] active_reg, active_next;
  logic [31:0] bufptr_reg, bufptr_next;
  logic [15:0] pktlen_reg, pktlen_next;
  logic [15:0] free_reg, free_next;
  logic [15:0] firstcnt_reg, firstcnt_next;
  logic [15:0] actcnt_reg, actcnt_next;
  logic [29:0] comp_reg, comp_next;
  logic        irq_reg, irq_next;
  logic        mvalid_reg, mvalid_next;
  logic [31:0] maddr_reg, maddr_next;
  logic [31:0] mdata_reg, mdata_next;
  logic [3:0]  mbe_reg, mbe_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [31:0] rd_word;
  logic        addr_hit;
  logic        wr_acc;
  logic        pop;
  logic        buf_valid;
  logic [8:0]  buf_data;

  // Stall-safe holding for received bytes
  rxd_pair_buffer #(
    .WIDTH (9),
    .DEPTH (2)
  ) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   ({rx_last, rx_data}),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  (buf_data)
  );

  // Bus answers and output wiring
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !addr_hit;
  assign prdata       = prdata_reg;
  assign mem_valid    = mvalid_reg;
  assign mem_addr     = maddr_reg;
  assign mem_wdata    = mdata_reg;
  assign mem_be       = mbe_reg;
  assign rx_queue_irq = irq_reg;
  assign wr_acc       = psel && penable && pwrite && addr_hit;
  assign pop          = (state_reg == rxd_pkg::RXD_BYTE) && mem_ready;

  // Read decode; reserved bits read zero
  always_comb
  begin
    addr_hit = 1'b1;
    rd_word  = rxd_pkg::RST_WORD;
    case (paddr)
      rxd_pkg::ADDR_SKIP:    rd_word = {24'h000000, skip_reg};
      rxd_pkg::ADDR_HEAD:    rd_word = {head_reg, 2'b00};
      rxd_pkg::ADDR_START:   rd_word = {first_reg, 1'b0, inpkt_reg};
      rxd_pkg::ADDR_ACTIVE:  rd_word = {active_reg, 2'b00};
      rxd_pkg::ADDR_BUFADDR: rd_word = bufptr_reg;
      rxd_pkg::ADDR_LENGTH:  rd_word = {pktlen_reg, free_reg};
      rxd_pkg::ADDR_COUNT:   rd_word = {firstcnt_reg, actcnt_reg};
      rxd_pkg::ADDR_COMP:    rd_word = {comp_reg, 2'b00};
      default:               addr_hit = 1'b0;
    endcase
  end

  // Software writes first, then channel sequencing overrides
  always_comb
  begin
    state_next    = state_reg;
    skip_next     = skip_reg;
    head_next     = head_reg;
    first_next    = first_reg;
    inpkt_next    = inpkt_reg;
    active_next   = active_reg;
    bufptr_next   = bufptr_reg;
    pktlen_next   = pktlen_reg;
    free_next     = free_reg;
    firstcnt_next = firstcnt_reg;
    actcnt_next   = actcnt_reg;
    comp_next     = comp_reg;
    irq_next      = irq_reg;
    mvalid_next   = mvalid_reg;
    maddr_next    = maddr_reg;
    mdata_next    = mdata_reg;
    mbe_next      = mbe_reg;
    prdata_next   = prdata_reg;
    // Read data latched in the setup cycle
    if (psel && !penable && !pwrite)
      prdata_next = rd_word;
    if (wr_acc)
    begin
      case (paddr)
        rxd_pkg::ADDR_SKIP:    skip_next = pwdata[rxd_pkg::SKIP_W-1:0];
        rxd_pkg::ADDR_HEAD:    head_next = pwdata[31:rxd_pkg::PTR_LSB];
        rxd_pkg::ADDR_START:
        begin
          first_next = pwdata[31:rxd_pkg::PTR_LSB];
          inpkt_next = pwdata[rxd_pkg::INPKT_BIT];
        end
        rxd_pkg::ADDR_ACTIVE:  active_next = pwdata[31:rxd_pkg::PTR_LSB];
        rxd_pkg::ADDR_BUFADDR: bufptr_next = pwdata;
        rxd_pkg::ADDR_LENGTH:
        begin
          pktlen_next = pwdata[31:rxd_pkg::HALF_LSB];
          free_next   = pwdata[rxd_pkg::HALF_LSB-1:0];
        end
        rxd_pkg::ADDR_COUNT:
        begin
          firstcnt_next = pwdata[31:rxd_pkg::HALF_LSB];
          actcnt_next   = pwdata[rxd_pkg::HALF_LSB-1:0];
        end
        rxd_pkg::ADDR_COMP:
        begin
          if (pwdata[rxd_pkg::MODE_BIT])
          begin
            comp_next = pwdata[31:rxd_pkg::PTR_LSB];
            irq_next  = 1'b1;
          end
          else if (pwdata[31:rxd_pkg::PTR_LSB] == comp_reg)
            irq_next = 1'b0;
        end
        default:
        begin
          skip_next = skip_reg;
        end
      endcase
    end
    case (state_reg)
      rxd_pkg::RXD_IDLE:
      begin
        if (buf_valid && !inpkt_reg)
        begin
          // Packet begins in the current buffer
          first_next    = active_reg;
          inpkt_next    = 1'b1;
          bufptr_next   = bufptr_reg + 32'(skip_reg);
          free_next     = (free_reg > 16'(skip_reg)) ? free_reg - 16'(skip_reg) : 16'h0000;
          pktlen_next   = rxd_pkg::RST_HALF;
          firstcnt_next = rxd_pkg::RST_HALF;
          actcnt_next   = rxd_pkg::RST_HALF;
        end
        else if (buf_valid && free_reg != 16'h0000)
        begin
          // Store one byte at the buffer pointer
          mvalid_next = 1'b1;
          maddr_next  = bufptr_reg;
          mdata_next  = {4{buf_data[7:0]}};
          mbe_next    = rxd_pkg::BE_BYTE0 << bufptr_reg[1:0];
          state_next  = rxd_pkg::RXD_BYTE;
        end
      end
      rxd_pkg::RXD_BYTE:
      begin
        if (mem_ready)
        begin
          bufptr_next = bufptr_reg + 32'h0000_0001;
          free_next   = free_reg - 16'h0001;
          pktlen_next = pktlen_reg + 16'h0001;
          actcnt_next = actcnt_reg + 16'h0001;
          if (active_reg == first_reg)
            firstcnt_next = firstcnt_reg + 16'h0001;
          if (buf_data[8])
          begin
            // Length goes into the word at byte offset 8 of the start descriptor
            maddr_next = {first_reg, 2'b00} + rxd_pkg::DESC_LEN_OFS;
            mdata_next = {16'h0000, pktlen_reg + 16'h0001};
            mbe_next   = rxd_pkg::BE_LOW_HALF;
            state_next = rxd_pkg::RXD_LEN;
          end
          else
          begin
            mvalid_next = 1'b0;
            state_next  = rxd_pkg::RXD_IDLE;
          end
        end
      end
      rxd_pkg::RXD_LEN:
      begin
        if (mem_ready)
        begin
          // Packet closed; queue event raised, set beats clear
          mvalid_next = 1'b0;
          inpkt_next  = 1'b0;
          comp_next   = active_reg;
          irq_next    = 1'b1;
          state_next  = rxd_pkg::RXD_IDLE;
        end
      end
      default:
      begin
        state_next = rxd_pkg::RXD_IDLE;
      end
    endcase
  end

  // State word registers, all zero from reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg    <= rxd_pkg::RXD_IDLE;
      skip_reg     <= rxd_pkg::RST_SKIP;
      head_reg     <= rxd_pkg::RST_PTR;
      first_reg    <= rxd_pkg::RST_PTR;
      inpkt_reg    <= 1'b0;
      active_reg   <= rxd_pkg::RST_PTR;
      bufptr_reg   <= rxd_pkg::RST_WORD;
      pktlen_reg   <= rxd_pkg::RST_HALF;
      free_reg     <= rxd_pkg::RST_HALF;
      firstcnt_reg <= rxd_pkg::RST_HALF;
      actcnt_reg   <= rxd_pkg::RST_HALF;
      comp_reg     <= rxd_pkg::RST_PTR;
      irq_reg      <= 1'b0;
      mvalid_reg   <= 1'b0;
      maddr_reg    <= rxd_pkg::RST_WORD;
      mdata_reg    <= rxd_pkg::RST_WORD;
      mbe_reg      <= 4'h0;
      prdata_reg   <= rxd_pkg::RST_WORD;
    end
    else
    begin
      state_reg    <= state_next;
      skip_reg     <= skip_next;
      head_reg     <= head_next;
      first_reg    <= first_next;
      inpkt_reg    <= inpkt_next;
      active_reg   <= active_next;
      bufptr_reg   <= bufptr_next;
      pktlen_reg   <= pktlen_next;
      free_reg     <= free_next;
      firstcnt_reg <= firstcnt_next;
      actcnt_reg   <= actcnt_next;
      comp_reg     <= comp_next;
      irq_reg      <= irq_next;
      mvalid_reg   <= mvalid_next;
      maddr_reg    <= maddr_next;
      mdata_reg    <= mdata_next;
      mbe_reg      <= mbe_next;
      prdata_reg   <= prdata_next;
    end
  end

  // Checks on the channel behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_of(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence

  sequence pkt_begin;
    state_reg == rxd_pkg::RXD_IDLE && buf_valid && !inpkt_reg;
  endsequence

  sequence byte_done;
    state_reg == rxd_pkg::RXD_BYTE && mem_ready;
  endsequence

  chk_head_reserved_zero: assert property (rd_of(rxd_pkg::ADDR_HEAD) |-> prdata[1:0] == 2'b00)
    else $error("head word low bits not zero");
  chk_inpkt_flag_read: assert property (rd_of(rxd_pkg::ADDR_START) |-> prdata[0] == $past(inpkt_reg))
    else $error("in-packet flag read wrong");
  chk_active_ptr_read: assert property (rd_of(rxd_pkg::ADDR_ACTIVE) |-> prdata[31:2] == $past(active_reg))
    else $error("active descriptor read wrong");
  chk_start_capture: assert property (pkt_begin |=> inpkt_reg && first_reg == $past(active_reg))
    else $error("start descriptor not captured");
  chk_skip_applied: assert property (pkt_begin |=> bufptr_reg == $past(bufptr_reg) + 32'($past(skip_reg)))
    else $error("skip offset not applied");
  chk_ptr_advance: assert property (byte_done |=> bufptr_reg == $past(bufptr_reg) + 32'h0000_0001)
    else $error("byte pointer did not advance");
  chk_free_count: assert property (byte_done |=> free_reg == $past(free_reg) - 16'h0001)
    else $error("free byte count did not drop");
  chk_len_write: assert property (byte_done ##0 buf_data[8] |=> mem_valid && mem_be == rxd_pkg::BE_LOW_HALF
      && mem_addr == {$past(first_reg), 2'b00} + rxd_pkg::DESC_LEN_OFS
      && mem_wdata[15:0] == $past(pktlen_reg) + 16'h0001)
    else $error("length write-back wrong");
  chk_eop_closes: assert property (state_reg == rxd_pkg::RXD_LEN && mem_ready |=> !inpkt_reg && irq_reg)
    else $error("end of packet not closed");
  chk_cmp_clear: assert property (psel && penable && pwrite && paddr == rxd_pkg::ADDR_COMP && !pwdata[0]
      && pwdata[31:2] == comp_reg && !(state_reg == rxd_pkg::RXD_LEN && mem_ready) |=> !irq_reg)
    else $error("compare write did not clear");
  chk_reset_idle: assert property (@(posedge pclk) disable iff (1'b0) !presetn |-> !inpkt_reg && !irq_reg
      && state_reg == rxd_pkg::RXD_IDLE && bufptr_reg == rxd_pkg::RST_WORD)
    else $error("state not cleared in reset");

endmodule

// >>> bench/rxd_mem_model.sv
// Memory model for the receive channel's write port.
// Assumes one request held until mem_ready is seen high at a rising edge.
`timescale 1ns/1ps
module rxd_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Write port
  input  wire logic        mem_valid,
  output logic             mem_ready,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [3:0]  mem_be,
  // Test control and record
  input  wire logic        stall,
  output logic      [7:0]  writes,
  output logic      [31:0] first_addr,
  output logic      [31:0] first_data,
  output logic      [3:0]  first_be,
  output logic      [31:0] last_addr,
  output logic      [15:0] last_len,
  output logic      [3:0]  last_be
);
  // Ready trails stall by a cycle, as a slow memory would
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mem_ready <= 1'b0;
    else
      mem_ready <= !stall;

  // Record first and last accepted writes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      writes     <= 8'h00;
      first_addr <= 32'h0000_0000;
      first_data <= 32'h0000_0000;
      first_be   <= 4'h0;
      last_addr  <= 32'h0000_0000;
      last_len   <= 16'h0000;
      last_be    <= 4'h0;
    end
    else if (mem_valid && mem_ready)
    begin
      writes <= writes + 8'h01;
      if (writes == 8'h00)
      begin
        first_addr <= mem_addr;
        first_data <= mem_wdata;
        first_be   <= mem_be;
      end
      last_addr <= mem_addr;
      last_len  <= mem_wdata[15:0];
      last_be   <= mem_be;
    end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the receive channel state block.
// Assumes the APB slave answers with pready and memory is the bench model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h seen %h", n, e, g); end end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, rx_valid, rx_last, stall;
  logic [7:0]  paddr, rx_data, writes;
  logic [31:0] pwdata, prdata, q, mem_addr, mem_wdata, first_addr, first_data, last_addr;
  logic        pready, pslverr, rx_ready, mem_valid, mem_ready, irq, err;
  logic [3:0]  mem_be, first_be, last_be;
  logic [15:0] last_len;
  int          checks, failures;

  rxd_channel i_rxd_channel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_last(rx_last), .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .rx_queue_irq(irq));
  rxd_mem_model i_rxd_mem_model (.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .stall(stall), .writes(writes), .first_addr(first_addr), .first_data(first_data),
    .first_be(first_be), .last_addr(last_addr), .last_len(last_len), .last_be(last_be));

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends at the first edge that sees pready high
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // One byte on the receive stream, held until accepted
  task automatic send(input logic [7:0] b, input logic l);
    @(posedge pclk);
    rx_valid <= 1'b1; rx_data <= b; rx_last <= l;
    do
    begin
      @(posedge pclk);
    end
    while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
  endtask

  // Reset values, reserved bits and unmapped access
  task automatic t_regs;
    for (int a = 0; a < 32; a += 4)
    begin
      apb(1'b0, a[7:0], 32'h0);
      `CHK("reset word", 32'h0000_0000, q)
    end
    `CHK("idle irq", 1'b0, irq)
    apb(1'b1, rxd_pkg::ADDR_HEAD, 32'hFFFF_FFFF);
    apb(1'b0, rxd_pkg::ADDR_HEAD, 32'h0);
    `CHK("head ptr", 32'hFFFF_FFFC, q)
    apb(1'b1, rxd_pkg::ADDR_ACTIVE, 32'hFFFF_FFFF);
    apb(1'b0, rxd_pkg::ADDR_ACTIVE, 32'h0);
    `CHK("active ptr", 32'hFFFF_FFFC, q)
    apb(1'b1, rxd_pkg::ADDR_BUFADDR, 32'hFFFF_FFFF);
    apb(1'b0, rxd_pkg::ADDR_BUFADDR, 32'h0);
    `CHK("buffer addr", 32'hFFFF_FFFF, q)
    apb(1'b1, rxd_pkg::ADDR_SKIP, 32'hFFFF_FFFF);
    apb(1'b0, rxd_pkg::ADDR_SKIP, 32'h0);
    `CHK("skip", 32'h0000_00FF, q)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, q)
    $display("test regs done");
  endtask

  // Three-byte packet with skip, memory stall and buffer full
  task automatic t_packet;
    int n;
    apb(1'b1, rxd_pkg::ADDR_SKIP, 32'h0000_0003);
    apb(1'b1, rxd_pkg::ADDR_ACTIVE, 32'h0000_1000);
    apb(1'b1, rxd_pkg::ADDR_BUFADDR, 32'h0000_2000);
    apb(1'b1, rxd_pkg::ADDR_LENGTH, 32'h0000_0010);
    stall <= 1'b1;
    send(8'hA5, 1'b0);
    send(8'h5A, 1'b0);
    repeat (2) @(posedge pclk);
    `CHK("buffer full", 1'b0, rx_ready)
    apb(1'b0, rxd_pkg::ADDR_START, 32'h0);
    `CHK("start word", 32'h0000_1001, q)
    stall <= 1'b0;
    send(8'h3C, 1'b1);
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    `CHK("first addr", 32'h0000_2003, first_addr)
    `CHK("first data", 32'hA5A5_A5A5, first_data)
    `CHK("first be", 4'h8, first_be)
    `CHK("writes", 8'h04, writes)
    `CHK("len addr", 32'h0000_1008, last_addr)
    `CHK("len value", 16'h0003, last_len)
    `CHK("len be", 4'h3, last_be)
    `CHK("done irq", 1'b1, irq)
    apb(1'b0, rxd_pkg::ADDR_START, 32'h0);
    `CHK("out of packet", 32'h0000_1000, q)
    apb(1'b0, rxd_pkg::ADDR_BUFADDR, 32'h0);
    `CHK("next byte addr", 32'h0000_2006, q)
    apb(1'b0, rxd_pkg::ADDR_LENGTH, 32'h0);
    `CHK("length word", 32'h0003_000A, q)
    apb(1'b0, rxd_pkg::ADDR_COUNT, 32'h0);
    `CHK("byte counts", 32'h0003_0003, q)
    $display("test packet done");
  endtask

  // Completion pointer compare and writeback modes
  task automatic t_comp;
    apb(1'b1, rxd_pkg::ADDR_COMP, 32'h0000_2000);
    @(posedge pclk);
    `CHK("mismatch keeps irq", 1'b1, irq)
    apb(1'b1, rxd_pkg::ADDR_COMP, 32'h0000_1000);
    @(posedge pclk);
    `CHK("match clears irq", 1'b0, irq)
    apb(1'b1, rxd_pkg::ADDR_COMP, 32'h0000_3001);
    @(posedge pclk);
    `CHK("writeback irq", 1'b1, irq)
    apb(1'b0, rxd_pkg::ADDR_COMP, 32'h0);
    `CHK("comp ptr", 32'h0000_3000, q)
    $display("test completion done");
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Clock at 25 ns
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = !pclk;
  end

  // Watchdog: the tests need under 1000 cycles
  initial
  begin
    #(25 * 5000);
    failures++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    checks = 0; failures = 0;
    presetn <= 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; rx_valid = 1'b0; rx_data = 8'h00; rx_last = 1'b0; stall = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_packet();
    t_comp();
    end_of_test();
  end
endmodule
